// File: hw/porws_consts.svh
// constants for the power-on reset and wake-up sequencer
// assumes a single 25 MHz clock; times in microseconds, clock in whole megahertz
`ifndef PORWS_CONSTS_SVH
`define PORWS_CONSTS_SVH

// -----------------------------------------------------------------------------
// timebase
// -----------------------------------------------------------------------------
`define PORWS_CLOCK_HZ           25000000
`define PORWS_US_TO_CYCLES(us)   ((us) * (`PORWS_CLOCK_HZ / 1000000))

// -----------------------------------------------------------------------------
// reset delay windows
// -----------------------------------------------------------------------------
`define PORWS_FAST_DELAY_MIN_US  3000
`define PORWS_FAST_DELAY_MAX_US  9000
`define PORWS_STD_DELAY_MIN_US   50000
`define PORWS_STD_DELAY_MAX_US   200000

// -----------------------------------------------------------------------------
// configuration clock limits
// -----------------------------------------------------------------------------
`define PORWS_AP_CLOCK_MAX_HZ    40000000
`define PORWS_FPP_CLOCK_MAX_HZ   100000000
`define PORWS_AP_HALF_PERIOD     ((`PORWS_CLOCK_HZ + 2 * `PORWS_AP_CLOCK_MAX_HZ - 1) / (2 * `PORWS_AP_CLOCK_MAX_HZ))

// -----------------------------------------------------------------------------
// mode select pin codes
// -----------------------------------------------------------------------------
`define PORWS_MSEL_AS_STD        4'h2
`define PORWS_MSEL_AS_FAST       4'hd
`define PORWS_MSEL_AP_FAST_A     4'h5
`define PORWS_MSEL_AP_FAST_B     4'h6
`define PORWS_MSEL_AP_FAST_C     4'h9
`define PORWS_MSEL_AP_STD_A      4'h7
`define PORWS_MSEL_AP_STD_B      4'h8
`define PORWS_MSEL_AP_STD_C      4'hb
`define PORWS_MSEL_AP_STD_D      4'ha
`define PORWS_MSEL_FPP           4'he

// -----------------------------------------------------------------------------
// initialization delay defaults
// -----------------------------------------------------------------------------
`define PORWS_INIT_DELAY_CYCLES  1000
`define PORWS_INIT_CLOCK_EDGES   300

`endif

// File: hw/porws_pkg.sv
// types for the power-on reset and wake-up sequencer
// assumes porws_consts.svh supplies the numeric constants
`default_nettype none

package porws_pkg;

  // ---------------------------------------------------------------------------
  // wake-up stages
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RAMP,
    ST_DELAY,
    ST_CONFIG,
    ST_INIT,
    ST_USER
  } porws_stage_t;

  // ---------------------------------------------------------------------------
  // configuration schemes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCH_ACTIVE_SERIAL,
    SCH_ACTIVE_PARALLEL,
    SCH_FAST_PASSIVE_PARALLEL,
    SCH_PASSIVE_SERIAL
  } porws_scheme_t;

endpackage

`default_nettype wire

// File: hw/porws_sequencer.sv
// power-on reset and wake-up sequencer: supply ramp, reset delay,
// configuration and initialization, then user mode with brown-out watch
// assumes supply-good levels and pins arrive asynchronously; the
// configuration engine answers on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "porws_consts.svh"

module porws_sequencer #(
  parameter int USER_IO_WIDTH     = 8,
  parameter int FAST_DELAY_CYCLES = `PORWS_US_TO_CYCLES(`PORWS_FAST_DELAY_MIN_US),
  parameter int STD_DELAY_CYCLES  = `PORWS_US_TO_CYCLES(`PORWS_STD_DELAY_MIN_US),
  parameter int INIT_DELAY_CYCLES = `PORWS_INIT_DELAY_CYCLES,
  parameter int INIT_CLOCK_EDGES  = `PORWS_INIT_CLOCK_EDGES
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_core_supply_good,
  input  wire logic                     i_analog_supply_good,
  input  wire logic                     i_io_supply_cfg_good,
  input  wire logic                     i_io_supply_other_good,
  input  wire logic [3:0]               i_mode_select_pins,
  input  wire logic                     i_reconfig_request_n,
  input  wire logic                     i_init_clock,
  input  wire logic                     i_init_clock_mode,
  input  wire logic                     i_compressed_data,
  input  wire logic                     i_config_done,
  input  wire logic [USER_IO_WIDTH-1:0] i_user_out,
  input  wire logic [USER_IO_WIDTH-1:0] i_user_oe,
  output logic                          o_device_reset_n,
  output logic                          o_config_start,
  output logic                          o_config_active,
  output logic                          o_config_error,
  output logic                          o_configuration_clock,
  output logic [1:0]                    o_scheme,
  output logic                          o_fast_delay,
  output logic                          o_init_active,
  output logic                          o_user_mode,
  output logic [2:0]                    o_stage,
  output logic [USER_IO_WIDTH-1:0]      o_user_out,
  output logic [USER_IO_WIDTH-1:0]      o_user_oe
);

  // ---------------------------------------------------------------------------
  // derived counts
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FAST_LAST = 32'(FAST_DELAY_CYCLES - 1);
  localparam logic [31:0] STD_LAST  = 32'(STD_DELAY_CYCLES - 1);
  localparam logic [31:0] INIT_LAST = 32'(INIT_DELAY_CYCLES - 1);
  localparam logic [31:0] EDGE_LAST = 32'(INIT_CLOCK_EDGES - 1);
  localparam logic [7:0]  HALF_LAST = 8'(`PORWS_AP_HALF_PERIOD - 1);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]                 sync1;
    logic [5:0]                 sync2;
    logic [3:0]                 msel1;
    logic [3:0]                 msel2;
    logic                       init_clk_prev;
    porws_pkg::porws_stage_t    stage;
    porws_pkg::porws_scheme_t   scheme;
    logic                       fast;
    logic [31:0]                count;
    logic                       cfg_active;
    logic                       cfg_start;
    logic                       cfg_error;
    logic                       cfg_clk;
    logic [7:0]                 div;
    logic                       reset_n;
    logic [USER_IO_WIDTH-1:0]   io_out;
    logic [USER_IO_WIDTH-1:0]   io_oe;
  } porws_reg_t;

  porws_reg_t q;
  porws_reg_t d;

  // ---------------------------------------------------------------------------
  // mode pin decoding
  // ---------------------------------------------------------------------------
  function automatic logic porws_is_fast(input logic [3:0] msel);
    case (msel)
      `PORWS_MSEL_AS_FAST:   porws_is_fast = 1'b1;
      `PORWS_MSEL_AP_FAST_A: porws_is_fast = 1'b1;
      `PORWS_MSEL_AP_FAST_B: porws_is_fast = 1'b1;
      `PORWS_MSEL_AP_FAST_C: porws_is_fast = 1'b1;
      default:               porws_is_fast = 1'b0;
    endcase
  endfunction

  function automatic porws_pkg::porws_scheme_t porws_scheme_of(input logic [3:0] msel);
    case (msel)
      `PORWS_MSEL_AS_STD,
      `PORWS_MSEL_AS_FAST:   porws_scheme_of = porws_pkg::SCH_ACTIVE_SERIAL;
      `PORWS_MSEL_AP_FAST_A,
      `PORWS_MSEL_AP_FAST_B,
      `PORWS_MSEL_AP_FAST_C,
      `PORWS_MSEL_AP_STD_A,
      `PORWS_MSEL_AP_STD_B,
      `PORWS_MSEL_AP_STD_C,
      `PORWS_MSEL_AP_STD_D:  porws_scheme_of = porws_pkg::SCH_ACTIVE_PARALLEL;
      `PORWS_MSEL_FPP:       porws_scheme_of = porws_pkg::SCH_FAST_PASSIVE_PARALLEL;
      default:               porws_scheme_of = porws_pkg::SCH_PASSIVE_SERIAL;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // synchronized inputs
  // ---------------------------------------------------------------------------
  logic core_ok;
  logic analog_ok;
  logic io_cfg_ok;
  logic io_other_ok;
  logic request_idle;
  logic init_clk_s;
  logic all_good;
  logic brown_out;
  logic init_edge;
  logic refuse;

  assign core_ok      = q.sync2[5];
  assign analog_ok    = q.sync2[4];
  assign io_cfg_ok    = q.sync2[3];
  assign io_other_ok  = q.sync2[2];
  assign request_idle = q.sync2[1];
  assign init_clk_s   = q.sync2[0];
  assign all_good     = core_ok & analog_ok & io_cfg_ok & io_other_ok;
  assign brown_out    = ~core_ok | ~analog_ok;
  assign init_edge    = init_clk_s & ~q.init_clk_prev;
  assign refuse       = (q.scheme == porws_pkg::SCH_FAST_PASSIVE_PARALLEL) &
                        i_compressed_data;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d               = q;
    d.sync1         = {i_core_supply_good, i_analog_supply_good, i_io_supply_cfg_good,
                       i_io_supply_other_good, i_reconfig_request_n, i_init_clock};
    d.sync2         = q.sync1;
    d.msel1         = i_mode_select_pins;
    d.msel2         = q.msel1;
    d.init_clk_prev = init_clk_s;
    d.cfg_start     = 1'b0;
    d.cfg_error     = refuse;

    case (q.stage)
      porws_pkg::ST_RAMP: begin
        d.count      = '0;
        d.cfg_active = 1'b0;
        if (all_good && request_idle) begin
          d.stage  = porws_pkg::ST_DELAY;
          d.fast   = porws_is_fast(q.msel2);
          d.scheme = porws_scheme_of(q.msel2);
        end
      end
      porws_pkg::ST_DELAY: begin
        if (!all_good) begin
          d.stage = porws_pkg::ST_RAMP;
          d.count = '0;
        end else if (q.count >= (q.fast ? FAST_LAST : STD_LAST)) begin
          d.stage = porws_pkg::ST_CONFIG;
          d.count = '0;
        end else begin
          d.count = q.count + 32'h0000_0001;
        end
      end
      porws_pkg::ST_CONFIG: begin
        if (brown_out) begin
          d.stage      = porws_pkg::ST_RAMP;
          d.cfg_active = 1'b0;
        end else if (!request_idle) begin
          d.cfg_active = 1'b0;
        end else if (!q.cfg_active) begin
          if (io_cfg_ok && !refuse) begin
            d.cfg_active = 1'b1;
            d.cfg_start  = 1'b1;
          end
        end else if (i_config_done) begin
          d.stage      = porws_pkg::ST_INIT;
          d.cfg_active = 1'b0;
          d.count      = '0;
        end
      end
      porws_pkg::ST_INIT: begin
        if (brown_out) begin
          d.stage = porws_pkg::ST_RAMP;
          d.count = '0;
        end else if (!request_idle) begin
          d.stage = porws_pkg::ST_CONFIG;
          d.count = '0;
        end else if (i_init_clock_mode) begin
          if (init_edge) begin
            if (q.count >= EDGE_LAST) begin
              d.stage = porws_pkg::ST_USER;
              d.count = '0;
            end else begin
              d.count = q.count + 32'h0000_0001;
            end
          end
        end else if (q.count >= INIT_LAST) begin
          d.stage = porws_pkg::ST_USER;
          d.count = '0;
        end else begin
          d.count = q.count + 32'h0000_0001;
        end
      end
      porws_pkg::ST_USER: begin
        if (brown_out) begin
          d.stage = porws_pkg::ST_RAMP;
        end else if (!request_idle) begin
          d.stage = porws_pkg::ST_CONFIG;
        end
      end
      default: begin
        d.stage      = porws_pkg::ST_RAMP;
        d.count      = '0;
        d.cfg_active = 1'b0;
      end
    endcase

    // active parallel configuration clock from the timebase
    if (d.cfg_active && (q.scheme == porws_pkg::SCH_ACTIVE_PARALLEL)) begin
      if (q.div >= HALF_LAST) begin
        d.div     = '0;
        d.cfg_clk = ~q.cfg_clk;
      end else begin
        d.div = q.div + 8'h01;
      end
    end else begin
      d.div     = '0;
      d.cfg_clk = 1'b0;
    end

    d.reset_n = (d.stage != porws_pkg::ST_RAMP) && (d.stage != porws_pkg::ST_DELAY);

    // user pins only drive once user mode is reached
    if (d.stage == porws_pkg::ST_USER) begin
      d.io_out = i_user_out;
      d.io_oe  = i_user_oe;
    end else begin
      d.io_out = '0;
      d.io_oe  = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_device_reset_n      = q.reset_n;
  assign o_config_start        = q.cfg_start;
  assign o_config_active       = q.cfg_active;
  assign o_config_error        = q.cfg_error;
  assign o_configuration_clock = q.cfg_clk;
  assign o_scheme              = q.scheme;
  assign o_fast_delay          = q.fast;
  assign o_init_active         = (q.stage == porws_pkg::ST_INIT);
  assign o_user_mode           = (q.stage == porws_pkg::ST_USER);
  assign o_stage               = q.stage;
  assign o_user_out            = q.io_out;
  assign o_user_oe             = q.io_oe;

endmodule // porws_sequencer

`default_nettype wire

// File: dv/porws_sequencer_properties.sv
// checker for the power-on reset and wake-up sequencer
// assumes it is bound into porws_sequencer and sees only its ports
`timescale 1ns/100ps
`default_nettype none

module porws_sequencer_properties #(
  parameter int USER_IO_WIDTH     = 8,
  parameter int FAST_DELAY_CYCLES = 20,
  parameter int STD_DELAY_CYCLES  = 40,
  parameter int INIT_DELAY_CYCLES = 5,
  parameter int INIT_CLOCK_EDGES  = 4
) (
  input wire logic                     i_clock,
  input wire logic                     i_arst_n,
  input wire logic                     i_core_supply_good,
  input wire logic                     i_analog_supply_good,
  input wire logic                     i_io_supply_cfg_good,
  input wire logic                     i_io_supply_other_good,
  input wire logic                     i_reconfig_request_n,
  input wire logic                     i_compressed_data,
  input wire logic                     i_init_clock_mode,
  input wire logic                     o_device_reset_n,
  input wire logic                     o_config_start,
  input wire logic                     o_config_active,
  input wire logic                     o_configuration_clock,
  input wire logic [1:0]               o_scheme,
  input wire logic                     o_fast_delay,
  input wire logic                     o_user_mode,
  input wire logic [2:0]               o_stage,
  input wire logic [USER_IO_WIDTH-1:0] o_user_oe
);
  // --------
  // stage history and cycles in the current stage
  // --------
  logic [2:0]  stg_q;
  logic [31:0] cnt_q;
  logic        all_good;
  logic        core_ok;

  assign core_ok  = i_core_supply_good & i_analog_supply_good;
  assign all_good = core_ok & i_io_supply_cfg_good & i_io_supply_other_good & i_reconfig_request_n;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stg_q <= 3'h0;
      cnt_q <= 32'h0;
    end else begin
      stg_q <= o_stage;
      cnt_q <= (o_stage == stg_q) ? cnt_q + 32'h1 : 32'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  sequence s_ramp_done;
    stg_q == 3'h0 && o_stage == 3'h1;
  endsequence
  sequence s_delay_done;
    stg_q == 3'h1 && o_stage == 3'h2;
  endsequence
  sequence s_init_done;
    stg_q == 3'h3 && o_stage == 3'h4;
  endsequence

  // --------
  // properties
  // --------
  reset_hold_a: assert property ((o_stage < 3'h2) == !o_device_reset_n)
    else $error("reset level wrong");
  pins_tristate_a: assert property (!o_user_mode |-> o_user_oe == '0)
    else $error("user pins driven early");
  supply_release_a: assert property (s_ramp_done |-> $past(all_good, 3))
    else $error("left ramp without supplies");
  bank_wait_a: assert property (o_config_start |-> $past(i_io_supply_cfg_good, 3))
    else $error("start without bank supply");
  brown_out_a: assert property (o_user_mode && !core_ok |-> ##[1:4] o_stage == 3'h0)
    else $error("no reset on brown-out");
  io_drop_a: assert property ($fell(o_user_mode) |->
      !$past(core_ok, 3) || !$past(i_reconfig_request_n, 3))
    else $error("left user mode without cause");
  delay_len_a: assert property (s_delay_done |->
      cnt_q == (o_fast_delay ? FAST_DELAY_CYCLES : STD_DELAY_CYCLES))
    else $error("reset delay length wrong");
  stage_order_a: assert property (o_stage != stg_q |-> o_stage == stg_q + 3'h1 ||
      o_stage == 3'h0 || (o_stage == 3'h2 && stg_q > 3'h2))
    else $error("stage order broken");
  no_compress_a: assert property (o_config_start |->
      !(o_scheme == 2'h2 && $past(i_compressed_data)))
    else $error("compressed data started");
  init_len_a: assert property (s_init_done |->
      (i_init_clock_mode ? cnt_q >= INIT_CLOCK_EDGES :
      cnt_q inside {[INIT_DELAY_CYCLES:INIT_DELAY_CYCLES + 1]}))
    else $error("init length wrong");
  cfg_clock_a: assert property (o_configuration_clock |->
      o_scheme == 2'h1 && (o_config_active || $past(o_config_active)))
    else $error("config clock out of place");
endmodule // porws_sequencer_properties

bind porws_sequencer porws_sequencer_properties #(
  .USER_IO_WIDTH    (USER_IO_WIDTH),
  .FAST_DELAY_CYCLES(FAST_DELAY_CYCLES),
  .STD_DELAY_CYCLES (STD_DELAY_CYCLES),
  .INIT_DELAY_CYCLES(INIT_DELAY_CYCLES),
  .INIT_CLOCK_EDGES (INIT_CLOCK_EDGES)
) i_props (.*);

`default_nettype wire

// File: dv/porws_board_model.sv
// board supplies and configuration host around the sequencer
// assumes the bench switches supplies and host pace on the same clock
`timescale 1ns/100ps
`default_nettype none

module porws_board_model (
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  input  wire logic [3:0] i_supply_on,
  input  wire logic       i_hold_reconfig,
  input  wire logic       i_slow,
  input  wire logic       i_config_active,
  output logic [3:0]      o_supply_good,
  output logic            o_reconfig_request_n,
  output logic            o_config_done,
  output logic            o_init_clock
);
  // --------
  // supply levels, host request and done answer
  // --------
  logic [2:0] wait_q;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_supply_good        <= 4'h0;
      o_reconfig_request_n <= 1'b0;
      o_config_done        <= 1'b0;
      o_init_clock         <= 1'b0;
      wait_q               <= 3'h0;
    end else begin
      o_supply_good        <= i_supply_on;
      o_reconfig_request_n <= ~i_hold_reconfig & (&o_supply_good | ~i_slow);
      // host paced by the board clock, far below the passive parallel clock limit
      o_config_done        <= i_config_active & (wait_q == (i_slow ? 3'h7 : 3'h1));
      o_init_clock         <= ~o_init_clock;
      wait_q               <= i_config_active ? wait_q + 3'h1 : 3'h0;
    end
  end
endmodule // porws_board_model

`default_nettype wire

// File: dv/tb_porws_sequencer.sv
// self-checking bench for the power-on reset and wake-up sequencer
// assumes the board model answers for supplies and the host
`timescale 1ns/100ps
`default_nettype none

module tb_porws_sequencer;
  localparam int FAST = 20;
  localparam int STD  = 40;

  logic       clock     = 1'b0;
  logic       arst_n    = 1'b0;
  logic [3:0] supply_on = 4'h0;
  logic       hold      = 1'b0;
  logic       slow      = 1'b0;
  logic [3:0] mode      = 4'h0;
  logic       init_mode = 1'b0;
  logic       comp      = 1'b0;
  logic [7:0] user_out  = 8'h00;
  logic [7:0] user_oe   = 8'h00;
  logic [3:0] good;
  logic       request_n, done, init_clk, reset_n, active, error, fast, user;
  logic       start, cclk, init;
  logic [1:0] scheme;
  logic [2:0] stage;
  logic [7:0] out_q, oe_q;
  int         n_fail       = 0;
  int         total_checks = 0;
  int         n_start      = 0;
  int         n_cclk       = 0;

  always #20 clock = ~clock;

  porws_board_model i_board (.i_clock(clock), .i_arst_n(arst_n), .i_supply_on(supply_on),
    .i_hold_reconfig(hold), .i_slow(slow), .i_config_active(active), .o_supply_good(good),
    .o_reconfig_request_n(request_n), .o_config_done(done), .o_init_clock(init_clk));

  porws_sequencer #(.FAST_DELAY_CYCLES(FAST), .STD_DELAY_CYCLES(STD),
    .INIT_DELAY_CYCLES(5), .INIT_CLOCK_EDGES(4)) i_dut (
    .i_clock(clock), .i_arst_n(arst_n), .i_core_supply_good(good[0]),
    .i_analog_supply_good(good[1]), .i_io_supply_cfg_good(good[2]),
    .i_io_supply_other_good(good[3]), .i_mode_select_pins(mode),
    .i_reconfig_request_n(request_n), .i_init_clock(init_clk), .i_init_clock_mode(init_mode),
    .i_compressed_data(comp), .i_config_done(done), .i_user_out(user_out), .i_user_oe(user_oe),
    .o_device_reset_n(reset_n), .o_config_start(start), .o_config_active(active),
    .o_config_error(error), .o_configuration_clock(cclk), .o_scheme(scheme), .o_fast_delay(fast),
    .o_init_active(init), .o_user_mode(user), .o_stage(stage), .o_user_out(out_q),
    .o_user_oe(oe_q));

  // counts start pulses and configuration clock high samples
  always @(negedge clock) begin
    if (start === 1'b1) n_start++;
    if (cclk === 1'b1) n_cclk++;
  end

  // --------
  // helpers
  // --------
  function automatic logic [1:0] exp_scheme(input logic [3:0] m);
    case (m)
      4'h2, 4'hd:                               return 2'h0;
      4'h5, 4'h6, 4'h9, 4'h7, 4'h8, 4'hb, 4'ha: return 2'h1;
      4'he:                                     return 2'h2;
      default:                                  return 2'h3;
    endcase
  endfunction

  function automatic logic exp_fast(input logic [3:0] m);
    return m inside {4'hd, 4'h5, 4'h6, 4'h9};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clock);
    arst_n    <= 1'b0;
    supply_on <= 4'h0;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
  endtask

  task automatic wait_for(input logic [2:0] s, input logic tri_chk);
    repeat (400) begin
      @(negedge clock);
      if (stage === s) break;
      if (tri_chk) check(oe_q, 8'h00);
    end
    check(stage, s);
  endtask

  task automatic power_up(input logic [3:0] m, input logic s);
    int n;
    int s0;
    int c0;
    @(posedge clock);
    mode      <= m;
    slow      <= s;
    init_mode <= 1'($urandom);
    user_out  <= 8'($urandom);
    user_oe   <= 8'($urandom) | 8'h01;
    do_reset();
    supply_on <= 4'hf;
    wait_for(3'h1, 1'b1);
    n  = 0;
    s0 = n_start;
    c0 = n_cclk;
    while (stage === 3'h1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check(scheme, exp_scheme(m));
    if (m != 4'he) begin
      check(fast, exp_fast(m));
      check(n, exp_fast(m) ? FAST : STD);
    end
    wait_for(3'h3, 1'b1);
    check(init, 1'b1);
    wait_for(3'h4, 1'b1);
    check(reset_n, 1'b1);
    check(user, 1'b1);
    check(n_start - s0, 1);
    check(n_cclk > c0, exp_scheme(m) == 2'h1);
    @(negedge clock);
    check(oe_q, user_oe);
    check(out_q, user_out);
  endtask

  // --------
  // tests
  // --------
  initial begin
    void'($urandom(32'haaa4));
    for (int m = 0; m < 16; m++) power_up(4'(m), 1'b0);
    $display("mode table done");
    for (int b = 0; b < 4; b++) begin
      do_reset();
      supply_on <= 4'hf & ~(4'h1 << b);
      repeat (30) @(negedge clock);
      check(stage, 3'h0);
      check(reset_n, 1'b0);
    end
    $display("partial supply done");
    power_up(4'hd, 1'b0);
    for (int b = 0; b < 4; b++) begin
      @(posedge clock);
      supply_on <= 4'hf & ~(4'h1 << b);
      repeat (8) @(negedge clock);
      check(stage, (b < 2) ? 3'h0 : 3'h4);
      check(oe_q, (b < 2) ? 8'h00 : user_oe);
      @(posedge clock);
      supply_on <= 4'hf;
      wait_for(3'h4, 1'b0);
    end
    $display("brown-out done");
    @(posedge clock);
    hold <= 1'b1;
    repeat (8) @(negedge clock);
    check(stage, 3'h2);
    check(active, 1'b0);
    @(posedge clock);
    hold <= 1'b0;
    wait_for(3'h4, 1'b0);
    $display("reconfiguration done");
    do_reset();
    mode      <= 4'he;
    comp      <= 1'b1;
    supply_on <= 4'hf;
    wait_for(3'h2, 1'b1);
    repeat (10) @(negedge clock);
    check(error, 1'b1);
    check(active, 1'b0);
    power_up(4'h0, 1'b0);
    $display("compression done");
    power_up(4'h2, 1'b1);
    $display("slow host done");
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule // tb_porws_sequencer

`default_nettype wire
